// ===== src/gpio_ports_pkg.sv
package gpio_ports_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PORT_D_W = 8;
  localparam int PORT_E_W = 5;
  localparam int PORT_F_W = 8;
  localparam int PULL_E_W = 4;
  localparam int REF_W = 3;

  // Register offsets
  localparam logic [15:0] PORT_D_LATCH_ADDR = 16'h0003;
  localparam logic [15:0] PORT_E_LATCH_ADDR = 16'h0008;
  localparam logic [15:0] PORT_F_LATCH_ADDR = 16'h0009;
  localparam logic [15:0] PORT_D_DIR_ADDR = 16'h0007;
  localparam logic [15:0] PORT_E_DIR_ADDR = 16'h000c;
  localparam logic [15:0] PORT_F_DIR_ADDR = 16'h000d;
  localparam logic [15:0] OPTICAL_CTL_ADDR = 16'h000e;

  // Optical control field positions
  localparam int OPT_X_BIT = 0;
  localparam int OPT_Y_BIT = 1;
  localparam int OPT_XREF_LSB = 2;
  localparam int OPT_YREF_LSB = 5;

  // Reset values and unmapped read value
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OPTICAL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Prescaler code that routes port-E pin 0 to the timer clock
  localparam logic [2:0] PRESCALE_EXT_CLK = 3'h7;

  // Slicing reference in mV: base + code * step
  localparam int REF_BASE_MV = 200;
  localparam int REF_STEP_MV = 100;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic enable_x;
    logic enable_y;
    logic divider_en;
    logic [2:0] slice_ref_x;
    logic [2:0] slice_ref_y;
  } optical_ctl_t;

  typedef struct packed {
    logic ch1_claim;
    logic ch0_claim;
    logic ch1_out;
    logic ch0_out;
    logic ch1_oe;
    logic ch0_oe;
    logic [2:0] prescaler_select;
  } timer_ctl_t;

endpackage

// ===== src/gpio_ports_def_optical.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
// What this block does
// - Reset clears port-D direction; one means output
// - Port-D read: latch if output, else pin
// - Latch writes always land, whatever direction
// - Driver on only when direction bit set, except claimed port-E pins 2,1, which take the timer channel oe
// - Port E: five latch, five direction, reset inputs
// - Port-E read: latch if output, else pin
// - Pins 2,1 become timer channels when claimed
// - Timer pins: direction only picks read source
// - Pin 0 feeds timer clock when selected
// - Port-E pull-ups only while pin is input
// - Port-E key enables route pins to interrupts
// - X enable: optical on pins 0,1, divider
// - Y enable: optical on pins 2,3, divider
// - Reference codes 0..7 give 200..900 mV
// - Port F latch writes land whatever direction; reset keeps
// - Port-F key enables route pins to interrupts
// - Port-F pull-ups only while pin is input
// - Reset leaves port-D latch unchanged
// - Port-D pull-ups follow key interrupt enables
// - Port-F read: latch if output, else pin
// - Reset clears port-F direction
module gpio_ports_def_optical (
  input wire logic core_clk,
  input wire logic rst_b,
  input gpio_ports_pkg::bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  output logic [7:0] port_d_pullup,
  input wire logic [4:0] port_e_in,
  output logic [4:0] port_e_out,
  output logic [4:0] port_e_oe,
  output logic [3:0] port_e_pullup,
  input wire logic [7:0] port_f_in,
  output logic [7:0] port_f_out,
  output logic [7:0] port_f_oe,
  output logic [7:0] port_f_pullup,
  input gpio_ports_pkg::timer_ctl_t timer_ctl,
  output logic timer_channel_0_pin,
  output logic timer_channel_1_pin,
  output logic timer_ext_clock_pin,
  input wire logic [7:0] port_d_key_irq_en,
  input wire logic [3:0] port_e_key_irq_en,
  input wire logic [7:0] port_f_key_irq_en,
  input wire logic [3:0] port_e_pullup_en,
  input wire logic [7:0] port_f_pullup_en,
  output logic [7:0] port_d_key_pins,
  output logic [3:0] port_e_key_pins,
  output logic [7:0] port_f_key_pins,
  output gpio_ports_pkg::optical_ctl_t optical_ctl
);

  logic [7:0] port_d_latch;
  logic [7:0] port_d_direction;
  logic [4:0] port_e_latch;
  logic [4:0] port_e_direction;
  logic [7:0] port_f_latch;
  logic [7:0] port_f_direction;
  logic [7:0] optical_input_control;
  logic [4:0] timer_owned;
  logic [4:0] next_e_out;
  logic [4:0] next_e_oe;
  logic [7:0] next_rdata;

  // Per bit: latch when driven, pin level otherwise
  function automatic logic [7:0] read_mux(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pin);
    read_mux = (dir & latch) | (~dir & pin);
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  // Latches have no reset so contents survive it
  always_ff @(posedge core_clk) begin
    if (bus_req.wr && hit(bus_req.addr, gpio_ports_pkg::PORT_D_LATCH_ADDR)) begin
      port_d_latch <= bus_req.wdata;
    end
    if (bus_req.wr && hit(bus_req.addr, gpio_ports_pkg::PORT_E_LATCH_ADDR)) begin
      port_e_latch <= bus_req.wdata[4:0];
    end
    if (bus_req.wr && hit(bus_req.addr, gpio_ports_pkg::PORT_F_LATCH_ADDR)) begin
      port_f_latch <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_d_direction <= gpio_ports_pkg::DIR_RESET;
      port_e_direction <= gpio_ports_pkg::DIR_RESET[4:0];
      port_f_direction <= gpio_ports_pkg::DIR_RESET;
      optical_input_control <= gpio_ports_pkg::OPTICAL_RESET;
    end else if (bus_req.wr) begin
      if (hit(bus_req.addr, gpio_ports_pkg::PORT_D_DIR_ADDR)) begin
        port_d_direction <= bus_req.wdata;
      end
      if (hit(bus_req.addr, gpio_ports_pkg::PORT_E_DIR_ADDR)) begin
        port_e_direction <= bus_req.wdata[4:0];
      end
      if (hit(bus_req.addr, gpio_ports_pkg::PORT_F_DIR_ADDR)) begin
        port_f_direction <= bus_req.wdata;
      end
      if (hit(bus_req.addr, gpio_ports_pkg::OPTICAL_CTL_ADDR)) begin
        optical_input_control <= bus_req.wdata;
      end
    end
  end

  // Timer ownership of port-E pins
  always_comb begin
    timer_owned = 5'h00;
    timer_owned[2] = timer_ctl.ch1_claim;
    timer_owned[1] = timer_ctl.ch0_claim;
    next_e_out = port_e_latch;
    next_e_oe = port_e_direction;
    if (timer_owned[2]) begin
      next_e_out[2] = timer_ctl.ch1_out;
      next_e_oe[2] = timer_ctl.ch1_oe;
    end
    if (timer_owned[1]) begin
      next_e_out[1] = timer_ctl.ch0_out;
      next_e_oe[1] = timer_ctl.ch0_oe;
    end
  end

  // Pin drive registered, costs one cycle after a write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_d_out <= 8'h00;
      port_d_oe <= 8'h00;
      port_e_out <= 5'h00;
      port_e_oe <= 5'h00;
      port_f_out <= 8'h00;
      port_f_oe <= 8'h00;
    end else begin
      port_d_out <= port_d_latch;
      port_d_oe <= port_d_direction;
      port_e_out <= next_e_out;
      port_e_oe <= next_e_oe;
      port_f_out <= port_f_latch;
      port_f_oe <= port_f_direction;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_d_pullup <= 8'h00;
      port_e_pullup <= 4'h0;
      port_f_pullup <= 8'h00;
    end else begin
      port_d_pullup <= port_d_key_irq_en;
      port_e_pullup <= port_e_pullup_en & ~next_e_oe[3:0];
      port_f_pullup <= port_f_pullup_en & ~port_f_direction;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_channel_0_pin <= 1'b0;
      timer_channel_1_pin <= 1'b0;
      timer_ext_clock_pin <= 1'b0;
      port_d_key_pins <= 8'h00;
      port_e_key_pins <= 4'h0;
      port_f_key_pins <= 8'h00;
    end else begin
      timer_channel_0_pin <= timer_owned[1] & port_e_in[1];
      timer_channel_1_pin <= timer_owned[2] & port_e_in[2];
      // Pin 0 still serves as general I/O either way
      timer_ext_clock_pin <= (timer_ctl.prescaler_select == gpio_ports_pkg::PRESCALE_EXT_CLK)
                             & port_e_in[0];
      port_d_key_pins <= port_d_key_irq_en & port_d_in;
      port_e_key_pins <= port_e_key_irq_en & port_e_in[3:0];
      port_f_key_pins <= port_f_key_irq_en & port_f_in;
    end
  end

  // Analog side maps code n to 200 mV plus n times 100 mV
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      optical_ctl <= '0;
    end else begin
      optical_ctl.enable_x <= optical_input_control[gpio_ports_pkg::OPT_X_BIT];
      optical_ctl.enable_y <= optical_input_control[gpio_ports_pkg::OPT_Y_BIT];
      optical_ctl.divider_en <= optical_input_control[gpio_ports_pkg::OPT_X_BIT]
                                | optical_input_control[gpio_ports_pkg::OPT_Y_BIT];
      optical_ctl.slice_ref_x <=
        optical_input_control[gpio_ports_pkg::OPT_XREF_LSB +: 3];
      optical_ctl.slice_ref_y <=
        optical_input_control[gpio_ports_pkg::OPT_YREF_LSB +: 3];
    end
  end

  always_comb begin
    next_rdata = gpio_ports_pkg::READ_UNMAPPED;
    case (bus_req.addr)
      gpio_ports_pkg::PORT_D_LATCH_ADDR: begin
        next_rdata = read_mux(port_d_direction, port_d_latch, port_d_in);
      end
      gpio_ports_pkg::PORT_E_LATCH_ADDR: begin
        // Direction picks source even for timer pins
        next_rdata = read_mux({3'h0, port_e_direction}, {3'h0, port_e_latch},
                              {3'h0, port_e_in});
      end
      gpio_ports_pkg::PORT_F_LATCH_ADDR: begin
        next_rdata = read_mux(port_f_direction, port_f_latch, port_f_in);
      end
      gpio_ports_pkg::PORT_D_DIR_ADDR: begin
        next_rdata = port_d_direction;
      end
      gpio_ports_pkg::PORT_E_DIR_ADDR: begin
        next_rdata = {3'h0, port_e_direction};
      end
      gpio_ports_pkg::PORT_F_DIR_ADDR: begin
        next_rdata = port_f_direction;
      end
      gpio_ports_pkg::OPTICAL_CTL_ADDR: begin
        next_rdata = optical_input_control;
      end
      default: begin
        next_rdata = gpio_ports_pkg::READ_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ===== verification/gpio_ports_def_optical_asserts.sv
`timescale 1ns/1ps
module gpio_ports_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input gpio_ports_pkg::bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic [7:0] port_d_in,
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] port_d_oe,
  input wire logic [7:0] port_d_pullup,
  input wire logic [7:0] port_d_key_irq_en,
  input wire logic [4:0] port_e_in,
  input wire logic [4:0] port_e_out,
  input wire logic [4:0] port_e_oe,
  input wire logic [3:0] port_e_pullup,
  input wire logic [3:0] port_e_pullup_en,
  input wire logic [7:0] port_f_oe,
  input wire logic [7:0] port_f_pullup,
  input wire logic [7:0] port_f_pullup_en,
  input gpio_ports_pkg::timer_ctl_t timer_ctl,
  input wire logic timer_ext_clock_pin,
  input gpio_ports_pkg::optical_ctl_t optical_ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(bus_req.rd) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  // Out and oe lag the latch and direction by one cycle, like rdata
  property p_d_read;
    $past(bus_req.rd) && $past(bus_req.addr) == gpio_ports_pkg::PORT_D_LATCH_ADDR
      |-> rdata == ((port_d_oe & port_d_out) | (~port_d_oe & $past(port_d_in)));
  endproperty
  a_d_read: assert property (p_d_read) else $error("port d read source wrong");
  property p_d_dir;
    bus_req.wr && bus_req.addr == gpio_ports_pkg::PORT_D_DIR_ADDR
      |=> ##1 port_d_oe == $past(bus_req.wdata, 2);
  endproperty
  a_d_dir: assert property (p_d_dir) else $error("port d driver enable wrong");
  property p_d_pull; $past(rst_b) |-> port_d_pullup == $past(port_d_key_irq_en); endproperty
  a_d_pull: assert property (p_d_pull) else $error("port d pull-up wrong");
  property p_e_pull;
    $past(rst_b) |-> port_e_pullup == ($past(port_e_pullup_en) & ~port_e_oe[3:0]);
  endproperty
  a_e_pull: assert property (p_e_pull) else $error("port e pull-up wrong");
  property p_f_pull;
    $past(rst_b) |-> port_f_pullup == ($past(port_f_pullup_en) & ~port_f_oe);
  endproperty
  a_f_pull: assert property (p_f_pull) else $error("port f pull-up wrong");
  property p_timer_ext_clock_pin;
    $past(rst_b) |-> timer_ext_clock_pin == ($past(port_e_in[0]) &&
      $past(timer_ctl.prescaler_select) == gpio_ports_pkg::PRESCALE_EXT_CLK);
  endproperty
  a_timer_ext_clock_pin: assert property (p_timer_ext_clock_pin) else $error("timer clock pin wrong");
  property p_ch1;
    $past(rst_b) && $past(timer_ctl.ch1_claim) |->
      port_e_oe[2] == $past(timer_ctl.ch1_oe) && port_e_out[2] == $past(timer_ctl.ch1_out);
  endproperty
  a_ch1: assert property (p_ch1) else $error("timer channel pin wrong");
  property p_opt;
    bus_req.wr && bus_req.addr == gpio_ports_pkg::OPTICAL_CTL_ADDR |=> ##1
      {optical_ctl.slice_ref_y, optical_ctl.slice_ref_x, optical_ctl.enable_y,
      optical_ctl.enable_x} == $past(bus_req.wdata, 2);
  endproperty
  a_opt: assert property (p_opt) else $error("optical control wrong");
  c_timer_ext_clock_pin: cover property (timer_ext_clock_pin);
  c_claim: cover property ($past(timer_ctl.ch1_claim) && port_e_oe[2]);
  c_dread: cover property ($past(bus_req.rd) && port_d_oe != 8'h00);
endmodule

bind gpio_ports_def_optical gpio_ports_asserts gpio_ports_asserts_inst (.core_clk, .rst_b,
  .bus_req, .rdata, .port_d_in, .port_d_out, .port_d_oe, .port_d_pullup, .port_d_key_irq_en,
  .port_e_in, .port_e_out, .port_e_oe, .port_e_pullup, .port_e_pullup_en, .port_f_oe,
  .port_f_pullup, .port_f_pullup_en, .timer_ctl, .timer_ext_clock_pin, .optical_ctl);

// ===== verification/pin_board.sv
`timescale 1ns/1ps
// Board side: floating pins wander with ext, never hold the last value
module pin_board #(parameter int W = 8) (
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  assign pin = (oe & out) | (~oe & pull) | (~oe & ~pull & ext);
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  gpio_ports_pkg::bus_req_t bus_req = '0;
  gpio_ports_pkg::timer_ctl_t timer_ctl = '0;
  gpio_ports_pkg::optical_ctl_t optical_ctl;
  logic [7:0] rdata, port_d_in, port_d_out, port_d_oe, port_d_pullup, port_d_key_pins;
  logic [7:0] port_f_in, port_f_out, port_f_oe, port_f_pullup, port_f_key_pins, pd, pf;
  logic [4:0] port_e_in, port_e_out, port_e_oe, pe;
  logic [3:0] port_e_pullup, port_e_key_pins;
  logic timer_channel_0_pin, timer_channel_1_pin, timer_ext_clock_pin;
  logic [7:0] port_d_key_irq_en = '0, port_f_key_irq_en = '0, port_f_pullup_en = '0;
  logic [3:0] port_e_key_irq_en = '0, port_e_pullup_en = '0;
  logic [7:0] ext_d = '0, ext_f = '0;
  logic [4:0] ext_e = '0;
  logic [7:0] regs [16];
  logic [15:0] amap [7] = '{gpio_ports_pkg::PORT_D_LATCH_ADDR, gpio_ports_pkg::PORT_E_LATCH_ADDR,
    gpio_ports_pkg::PORT_F_LATCH_ADDR, gpio_ports_pkg::PORT_D_DIR_ADDR,
    gpio_ports_pkg::PORT_E_DIR_ADDR, gpio_ports_pkg::PORT_F_DIR_ADDR,
    gpio_ports_pkg::OPTICAL_CTL_ADDR};
  int errors = 0;
  int tests_run = 0;

  always #20 core_clk = ~core_clk;

  gpio_ports_def_optical gpio_ports_def_optical_inst (.*);
  pin_board #(.W(8)) pin_board_d_inst (.oe(port_d_oe), .out(port_d_out), .pull(port_d_pullup),
    .ext(ext_d), .pin(port_d_in));
  pin_board #(.W(5)) pin_board_e_inst (.oe(port_e_oe), .out(port_e_out),
    .pull({1'b0, port_e_pullup}), .ext(ext_e), .pin(port_e_in));
  pin_board #(.W(8)) pin_board_f_inst (.oe(port_f_oe), .out(port_f_out), .pull(port_f_pullup),
    .ext(ext_f), .pin(port_f_in));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    case (a)
      gpio_ports_pkg::PORT_D_LATCH_ADDR: return (regs[7] & regs[3]) | (~regs[7] & pd);
      gpio_ports_pkg::PORT_E_LATCH_ADDR: return (regs[12] & regs[8]) | (~regs[12] & {3'h0, pe});
      gpio_ports_pkg::PORT_F_LATCH_ADDR: return (regs[13] & regs[9]) | (~regs[13] & pf);
      default: return (a inside {amap}) ? regs[a[3:0]] : 8'h00;
    endcase
  endfunction

  // Pins are snapshot between edges, where the board cannot move them
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge core_clk);
    pd = port_d_in;
    pe = port_e_in;
    pf = port_f_in;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
    if (!w) begin
      chk($sformatf("rdata %h", a), rdata, exp_rd(a));
    end else if (a inside {amap}) begin
      regs[a[3:0]] = (a inside {gpio_ports_pkg::PORT_E_LATCH_ADDR,
        gpio_ports_pkg::PORT_E_DIR_ADDR}) ? d & 8'h1f : d;
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'h7e17));
    for (int i = 3; i < 7; i++) regs[amap[i][3:0]] = 8'h00;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (amap[i]) acc(1'b0, amap[i], 8'h00);
    for (int i = 0; i < 3; i++) acc(1'b1, amap[i], 8'($urandom));
    acc(1'b1, 16'h0013, 8'h5a);
    acc(1'b0, 16'h0013, 8'h00);
    repeat (80) begin
      @(posedge core_clk);
      {ext_d, ext_e, ext_f} <= 21'($urandom);
      timer_ctl <= 9'($urandom);
      {port_d_key_irq_en, port_f_key_irq_en, port_e_key_irq_en, port_e_pullup_en} <= 24'($urandom);
      port_f_pullup_en <= 8'($urandom);
      acc(1'($urandom), amap[$urandom_range(6)], 8'($urandom));
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, gpio_ports_pkg::OPTICAL_CTL_ADDR, {i[2:0], i[2:0], i[1:0]});
      @(posedge core_clk);
      #1;
      chk("slice_ref_x", 8'(optical_ctl.slice_ref_x), 8'(i));
      chk("optical enables", 8'({optical_ctl.divider_en, optical_ctl.enable_y,
        optical_ctl.enable_x}), 8'({i[1] | i[0], i[1:0]}));
    end
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    chk("port_f_oe", port_f_oe, 8'h00);
    for (int i = 3; i < 7; i++) regs[amap[i][3:0]] = 8'h00;
    foreach (amap[i]) acc(1'b0, amap[i], 8'h00);
    for (int i = 3; i < 6; i++) acc(1'b1, amap[i], 8'hff);
    for (int i = 0; i < 3; i++) acc(1'b0, amap[i], 8'h00);
    summarize();
  end
endmodule
